/* File: rtl/ubdmc_addr_cmp.sv */
/*
 * Address comparator of one break channel for data and fetch cycles.
 * Assumes the access size of the bus cycle is valid with the address.
 */
`timescale 1ns/1ps
module ubdmc_addr_cmp
	import ubdmc_pkg::*;
(
	input  wire logic [31:0] addr_i,     // Address of the bus cycle.
	input  wire logic [31:0] ref_i,      // Break address of the channel.
	input  wire logic [1:0]  size_sel_i, // Programmed operand size.
	input  wire logic [1:0]  bus_size_i, // Size of the bus cycle.
	output logic             match_o     // Address condition met.
);

	logic [1:0]  eff_size;
	logic [31:0] care;

	// ****************************************************************
	// Low bits dropped according to the operand size.
	// ****************************************************************
	// With no size programmed the cycle's own size picks the bits.
	always_comb begin
		eff_size = (size_sel_i == UBDMC_SZ_ANY) ? bus_size_i : size_sel_i;
		unique case (eff_size)
			UBDMC_SZ_LONG: care = 32'hFFFF_FFFC;
			UBDMC_SZ_WORD: care = 32'hFFFF_FFFE;
			default:       care = 32'hFFFF_FFFF;
		endcase
		match_o = (((addr_i ^ ref_i) & care) == 32'h0000_0000);
	end

endmodule : ubdmc_addr_cmp

/* File: rtl/ubdmc_data_cmp.sv */
/*
 * Masked data comparator of channel B.
 * Assumes software has mirrored byte data into both low bytes.
 */
`timescale 1ns/1ps
module ubdmc_data_cmp
	import ubdmc_pkg::*;
(
	input  wire logic [31:0] data_i,   // Data bus value of the cycle.
	input  wire logic [31:0] value_i,  // Break data of channel B.
	input  wire logic [31:0] mask_i,   // One excludes the bit.
	input  wire logic [1:0]  size_i,   // Programmed operand size.
	output logic             match_o   // Masked data condition met.
);

	logic [31:0] care;

	// ****************************************************************
	// Bitwise masked compare.
	// ****************************************************************
	// Byte and word sizes look at the low half only.
	always_comb begin
		care = ~mask_i;
		if (size_i == UBDMC_SZ_BYTE || size_i == UBDMC_SZ_WORD) begin
			care[31:16] = 16'h0000;
		end
		match_o = (((data_i ^ value_i) & care) == 32'h0000_0000);
	end

endmodule : ubdmc_data_cmp

/* File: rtl/ubdmc_pkg.sv */
/*
 * Constants shared by the user break data mask and control block:
 * register offsets, field positions, reset values and size encodings.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package ubdmc_pkg;

	// ****************************************************************
	// Register map, byte addresses of aligned 32-bit words.
	// ****************************************************************
	localparam logic [7:0] UBDMC_OFF_MASK_B   = 8'h00;
	localparam logic [7:0] UBDMC_OFF_CONTROL  = 8'h04;
	localparam logic [7:0] UBDMC_OFF_INT_STAT = 8'h08;
	localparam logic [7:0] UBDMC_OFF_INT_MASK = 8'h0C;

	// ****************************************************************
	// Break control field positions and reset value.
	// ****************************************************************
	localparam int UBDMC_BIT_FLAG_A  = 15;
	localparam int UBDMC_BIT_FLAG_B  = 14;
	localparam int UBDMC_BIT_AFTER_A = 10;
	localparam int UBDMC_BIT_DATA_EN = 7;
	localparam int UBDMC_BIT_AFTER_B = 6;
	localparam int UBDMC_BIT_CHAIN   = 3;
	localparam logic [15:0] UBDMC_CONTROL_RST = 16'h0000;

	// ****************************************************************
	// Interrupt status and mask layout.
	// ****************************************************************
	localparam int UBDMC_INT_W        = 3;
	localparam int UBDMC_INT_MATCH_A  = 0;
	localparam int UBDMC_INT_MATCH_B  = 1;
	localparam int UBDMC_INT_TRAP     = 2;
	localparam logic [2:0] UBDMC_INT_RST = 3'h0;

	// ****************************************************************
	// Operand size encodings of the bus cycle condition and the bus.
	// ****************************************************************
	localparam logic [1:0] UBDMC_SZ_ANY  = 2'h0;
	localparam logic [1:0] UBDMC_SZ_BYTE = 2'h1;
	localparam logic [1:0] UBDMC_SZ_WORD = 2'h2;
	localparam logic [1:0] UBDMC_SZ_LONG = 2'h3;

endpackage : ubdmc_pkg

/* File: rtl/ubdmc_top.sv */
/*
 * User break data mask and break control block with a Wishbone slave.
 * Holds the channel B data mask, the break control register and an
 * interrupt status/mask pair; compares core bus cycles and raises
 * break trap pulses. Assumes the channel address, bus cycle and break
 * data registers sit outside and arrive as plain inputs, and that the
 * core bus inputs are synchronous to clk_i.
 */
`timescale 1ns/1ps
module ubdmc_top
	import ubdmc_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input  wire logic        clk_i,          // System clock, 20 MHz.
	input  wire logic        rst_i,          // Synchronous reset, high.
	input  wire logic        wb_cyc_i,       // Wishbone cycle.
	input  wire logic        wb_stb_i,       // Wishbone strobe.
	input  wire logic        wb_we_i,        // Wishbone write enable.
	input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address.
	input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects.
	input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
	output logic [31:0]      wb_dat_o,       // Wishbone read data.
	output logic             wb_ack_o,       // Wishbone acknowledge.
	input  wire logic        bus_valid_i,    // Core bus cycle this clock.
	input  wire logic        bus_fetch_i,    // Cycle is a fetch.
	input  wire logic [31:0] bus_addr_i,     // Core bus address.
	input  wire logic [31:0] bus_data_i,     // Core bus data.
	input  wire logic [1:0]  bus_size_i,     // Core bus access size.
	input  wire logic        cond_ok_a_i,    // A cycle/ASID terms met.
	input  wire logic [31:0] break_addr_a_i, // Channel A break address.
	input  wire logic [1:0]  size_sel_a_i,   // Channel A size select.
	input  wire logic        cond_ok_b_i,    // B cycle/ASID terms met.
	input  wire logic [31:0] break_addr_b_i, // Channel B break address.
	input  wire logic [1:0]  size_sel_b_i,   // Channel B size select.
	input  wire logic [31:0] break_data_value_b_i, // Channel B data.
	output logic             break_trap_o,   // Break trap, one pulse.
	output logic             break_after_o,  // Trap is post-execution.
	output logic             irq_o           // Interrupt, level.
);

	// ****************************************************************
	// Elaboration check.
	// ****************************************************************
	generate
		if (DATA_W != 32) begin : g_bad_width
			$error("ubdmc_top serves a 32-bit data bus only");
		end
	endgenerate

	// ****************************************************************
	// State.
	// ****************************************************************
	typedef struct packed {
		logic [31:0]            mask_b;
		logic                   flag_a;
		logic                   flag_b;
		logic                   after_a;
		logic                   data_en;
		logic                   after_b;
		logic                   chain;
		logic                   a_seen;
		logic [UBDMC_INT_W-1:0] int_stat;
		logic [UBDMC_INT_W-1:0] int_mask;
		logic                   ack;
		logic [31:0]            dat;
		logic                   trap;
		logic                   after;
		logic                   irq;
	} ubdmc_state_t;

	ubdmc_state_t state_reg;
	ubdmc_state_t state_next;

	logic addr_match_a;
	logic addr_match_b;
	logic data_match_b;

	// ****************************************************************
	// Comparators.
	// ****************************************************************
	ubdmc_addr_cmp u_addr_a (
		.addr_i     (bus_addr_i),
		.ref_i      (break_addr_a_i),
		.size_sel_i (size_sel_a_i),
		.bus_size_i (bus_size_i),
		.match_o    (addr_match_a)
	);

	ubdmc_addr_cmp u_addr_b (
		.addr_i     (bus_addr_i),
		.ref_i      (break_addr_b_i),
		.size_sel_i (size_sel_b_i),
		.bus_size_i (bus_size_i),
		.match_o    (addr_match_b)
	);

	ubdmc_data_cmp u_data_b (
		.data_i  (bus_data_i),
		.value_i (break_data_value_b_i),
		.mask_i  (state_reg.mask_b),
		.size_i  (size_sel_b_i),
		.match_o (data_match_b)
	);

	// ****************************************************************
	// Helpers.
	// ****************************************************************
	// Merges write data into an old word under the byte selects.
	function automatic logic [31:0] ubdmc_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction : ubdmc_merge

	// Assembles the break control word; unused bits stay zero.
	function automatic logic [15:0] ubdmc_ctrl_word(input ubdmc_state_t s);
		logic [15:0] w;
		w = UBDMC_CONTROL_RST;
		w[UBDMC_BIT_FLAG_A]  = s.flag_a;
		w[UBDMC_BIT_FLAG_B]  = s.flag_b;
		w[UBDMC_BIT_AFTER_A] = s.after_a;
		w[UBDMC_BIT_DATA_EN] = s.data_en;
		w[UBDMC_BIT_AFTER_B] = s.after_b;
		w[UBDMC_BIT_CHAIN]   = s.chain;
		return w;
	endfunction : ubdmc_ctrl_word

	// ****************************************************************
	// Next state.
	// ****************************************************************
	always_comb begin
		logic        req;
		logic        wr;
		logic        raw_a;
		logic        raw_b;
		logic        hit_a;
		logic        hit_b;
		logic [31:0] wv;
		logic [31:0] ctrl_old;
		logic [UBDMC_INT_W-1:0] ev;
		logic [UBDMC_INT_W-1:0] clr;

		state_next = state_reg;
		req = wb_cyc_i && wb_stb_i;
		wr  = req && wb_we_i && state_reg.ack;
		wv  = 32'h0000_0000;
		ctrl_old = {16'h0000, ubdmc_ctrl_word(state_reg)};
		clr = UBDMC_INT_RST;
		ev  = UBDMC_INT_RST;
		{raw_a, raw_b, hit_a, hit_b} = 4'h0;

		// Channel conditions of the current core bus cycle.
		raw_a = bus_valid_i && cond_ok_a_i && addr_match_a;
		raw_b = bus_valid_i && cond_ok_b_i && addr_match_b;
		if (state_reg.data_en) begin
			raw_b = raw_b && !bus_fetch_i && data_match_b;
		end
		// Chained mode ignores A's own flag and a B match that is not
		// strictly later than an earlier A match.
		hit_a = raw_a && !state_reg.chain;
		hit_b = state_reg.chain ? (raw_b && state_reg.a_seen) : raw_b;
		if (state_reg.chain) begin
			state_next.a_seen = (state_reg.a_seen || raw_a) && !hit_b;
		end else begin
			state_next.a_seen = 1'b0;
		end

		// Bus ack one cycle after the request, dropped the cycle after.
		state_next.ack = req && !state_reg.ack;
		state_next.dat = 32'h0000_0000;
		if (req && !state_reg.ack && !wb_we_i) begin
			unique case (wb_adr_i)
				UBDMC_OFF_MASK_B:   state_next.dat = state_reg.mask_b;
				UBDMC_OFF_CONTROL:  state_next.dat = ctrl_old;
				UBDMC_OFF_INT_STAT: state_next.dat[UBDMC_INT_W-1:0] =
					state_reg.int_stat;
				UBDMC_OFF_INT_MASK: state_next.dat[UBDMC_INT_W-1:0] =
					state_reg.int_mask;
				default:            state_next.dat = 32'h0000_0000;
			endcase
		end

		// Register writes take effect at the edge that sees ack high.
		if (wr) begin
			unique case (wb_adr_i)
				UBDMC_OFF_MASK_B: begin
					state_next.mask_b = ubdmc_merge(state_reg.mask_b,
						wb_dat_i, wb_sel_i);
				end
				UBDMC_OFF_CONTROL: begin
					wv = ubdmc_merge(ctrl_old, wb_dat_i, wb_sel_i);
					// A one leaves a flag alone, a zero clears it.
					state_next.flag_a = state_reg.flag_a &&
						wv[UBDMC_BIT_FLAG_A];
					state_next.flag_b = state_reg.flag_b &&
						wv[UBDMC_BIT_FLAG_B];
					state_next.after_a = wv[UBDMC_BIT_AFTER_A];
					state_next.data_en = wv[UBDMC_BIT_DATA_EN];
					state_next.after_b = wv[UBDMC_BIT_AFTER_B];
					state_next.chain   = wv[UBDMC_BIT_CHAIN];
				end
				UBDMC_OFF_INT_STAT: begin
					if (wb_sel_i[0]) begin
						clr = wb_dat_i[UBDMC_INT_W-1:0];
					end
				end
				UBDMC_OFF_INT_MASK: begin
					if (wb_sel_i[0]) begin
						state_next.int_mask = wb_dat_i[UBDMC_INT_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// Hardware sets win over a clear in the same cycle.
		state_next.flag_a = state_next.flag_a || hit_a;
		state_next.flag_b = state_next.flag_b || hit_b;

		// Trap pulse; a data access always breaks after the instruction.
		state_next.trap  = hit_a || hit_b;
		state_next.after = !bus_fetch_i ||
			((!hit_a || state_reg.after_a) &&
			 (!hit_b || state_reg.after_b));

		// Sticky interrupt events, write one to clear, set wins.
		ev[UBDMC_INT_MATCH_A] = hit_a;
		ev[UBDMC_INT_MATCH_B] = hit_b;
		ev[UBDMC_INT_TRAP]    = hit_a || hit_b;
		state_next.int_stat = (state_reg.int_stat & ~clr) | ev;

		// Reset clears control state but leaves the data mask alone.
		if (rst_i) begin
			state_next.flag_a   = UBDMC_CONTROL_RST[UBDMC_BIT_FLAG_A];
			state_next.flag_b   = UBDMC_CONTROL_RST[UBDMC_BIT_FLAG_B];
			state_next.after_a  = UBDMC_CONTROL_RST[UBDMC_BIT_AFTER_A];
			state_next.data_en  = UBDMC_CONTROL_RST[UBDMC_BIT_DATA_EN];
			state_next.after_b  = UBDMC_CONTROL_RST[UBDMC_BIT_AFTER_B];
			state_next.chain    = UBDMC_CONTROL_RST[UBDMC_BIT_CHAIN];
			state_next.a_seen   = 1'b0;
			state_next.int_stat = UBDMC_INT_RST;
			state_next.int_mask = UBDMC_INT_RST;
			state_next.ack      = 1'b0;
			state_next.dat      = 32'h0000_0000;
			state_next.trap     = 1'b0;
			state_next.after    = 1'b0;
		end

		// Interrupt follows the status that will be stored.
		state_next.irq = |(state_next.int_stat & state_next.int_mask);
	end

	// ****************************************************************
	// State register.
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		state_reg <= state_next;
	end

	// ****************************************************************
	// Outputs, straight from the state flip-flops.
	// ****************************************************************
	assign wb_dat_o      = state_reg.dat;
	assign wb_ack_o      = state_reg.ack;
	assign break_trap_o  = state_reg.trap;
	assign break_after_o = state_reg.after;
	assign irq_o         = state_reg.irq;

endmodule : ubdmc_top

/* File: tb/testbench.sv */
/* Self-checking bench: Wishbone register tasks and core cycles.
   Assumes one 20 MHz clock and the constants of the package. */
`timescale 1ns/1ps
module testbench;
	import ubdmc_pkg::*;
	localparam logic [7:0] CTL = UBDMC_OFF_CONTROL;
	localparam logic [7:0] MSK = UBDMC_OFF_MASK_B;
	localparam logic [7:0] IST = UBDMC_OFF_INT_STAT;
	localparam logic [7:0] IMK = UBDMC_OFF_INT_MASK;
	localparam logic [1:0] SB  = UBDMC_SZ_BYTE;
	localparam logic [1:0] SW  = UBDMC_SZ_WORD;
	localparam logic [1:0] SL  = UBDMC_SZ_LONG;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        bus_valid_i, bus_fetch_i, cond_ok_a_i, cond_ok_b_i;
	logic        break_trap_o, break_after_o, irq_o;
	logic [1:0]  bus_size_i, size_sel_a_i, size_sel_b_i;
	logic [3:0]  wb_sel_i;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, bus_addr_i, bus_data_i, q;
	logic [31:0] break_addr_a_i, break_addr_b_i, break_data_value_b_i;
	int          num_errors, total_checks;

	ubdmc_top i_dut (
		.clk_i                (clk_i),
		.rst_i                (rst_i),
		.wb_cyc_i             (wb_cyc_i),
		.wb_stb_i             (wb_stb_i),
		.wb_we_i              (wb_we_i),
		.wb_adr_i             (wb_adr_i),
		.wb_sel_i             (wb_sel_i),
		.wb_dat_i             (wb_dat_i),
		.wb_dat_o             (wb_dat_o),
		.wb_ack_o             (wb_ack_o),
		.bus_valid_i          (bus_valid_i),
		.bus_fetch_i          (bus_fetch_i),
		.bus_addr_i           (bus_addr_i),
		.bus_data_i           (bus_data_i),
		.bus_size_i           (bus_size_i),
		.cond_ok_a_i          (cond_ok_a_i),
		.break_addr_a_i       (break_addr_a_i),
		.size_sel_a_i         (size_sel_a_i),
		.cond_ok_b_i          (cond_ok_b_i),
		.break_addr_b_i       (break_addr_b_i),
		.size_sel_b_i         (size_sel_b_i),
		.break_data_value_b_i (break_data_value_b_i),
		.break_trap_o         (break_trap_o),
		.break_after_o        (break_after_o),
		.irq_o                (irq_o)
	);
	ubdmc_core_model i_core (.clk_i(clk_i), .valid_o(bus_valid_i),
		.fetch_o(bus_fetch_i), .addr_o(bus_addr_i),
		.data_o(bus_data_i), .size_o(bus_size_i));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// ****************************************
	// Tasks.
	// ****************************************
	task end_sim;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	task check(input string n, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : check

	// A lost ack counts as a mismatch and ends the run.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		{wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'hF, d};
		for (n = 0; n < 8; n++) begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1)
				break;
		end
		r = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
		if (n == 8) begin
			num_errors++;
			end_sim();
		end
	endtask : wb

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, q);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e, input string n);
		wb(1'b0, a, 32'h0, q);
		check(n, e, q);
	endtask : rd

	// The trap is looked at in the one cycle that it stands.
	task hit(input logic f, input logic [31:0] a, d,
		input logic [1:0] s, input logic t, af);
		i_core.cycle(f, a, d, s);
		#1;
		check("trap", 32'(t), 32'(break_trap_o));
		if (t)
			check("after", 32'(af), 32'(break_after_o));
		@(posedge clk_i);
	endtask : hit

	task do_reset;
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask : do_reset

	// ****************************************
	// Main sequence.
	// ****************************************
	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, cond_ok_a_i, cond_ok_b_i} = '0;
		{wb_adr_i, wb_sel_i, wb_dat_i, size_sel_a_i, size_sel_b_i} = '0;
		{break_addr_a_i, break_addr_b_i, break_data_value_b_i} = '0;
		{num_errors, total_checks} = '0;
		do_reset();
		rd(CTL, 32'h0, "control");
		wr(MSK, 32'h1234_5678);
		wr(CTL, 32'hFFFF_FFFF);
		rd(CTL, 32'h04C8, "control");
		rd(8'h40, 32'h0, "unmapped");
		do_reset();
		rd(MSK, 32'h1234_5678, "mask");
		rd(CTL, 32'h0, "control");
		wr(IMK, 32'h7);
		hit(1'b1, 32'h100, 32'h0, SL, 1'b0, 1'b0);
		{cond_ok_a_i, break_addr_a_i, size_sel_a_i} <= {1'b1, 32'h100, SL};
		hit(1'b1, 32'h100, 32'h0, SL, 1'b1, 1'b0);
		rd(CTL, 32'h8000, "control");
		wr(CTL, 32'h8000);
		rd(CTL, 32'h8000, "control");
		wr(CTL, 32'h0400);
		rd(CTL, 32'h0400, "control");
		hit(1'b1, 32'h100, 32'h0, SL, 1'b1, 1'b1);
		check("irq", 32'h1, 32'(irq_o));
		rd(IST, 32'h5, "status");
		wr(IMK, 32'h0);
		rd(IMK, 32'h0, "int mask");
		check("irq", 32'h0, 32'(irq_o));
		wr(IST, 32'h7);
		rd(IST, 32'h0, "status");
		wr(IMK, 32'h7);
		// Channel B alone, data first left out of the condition.
		{cond_ok_a_i, cond_ok_b_i, break_addr_b_i, size_sel_b_i} <=
			{2'b01, 32'h200, SW};
		break_data_value_b_i <= 32'hAAAA_1234;
		wr(CTL, 32'h0040);
		hit(1'b1, 32'h200, 32'h0, SW, 1'b1, 1'b1);
		rd(CTL, 32'h4040, "control");
		wr(CTL, 32'h0);
		hit(1'b0, 32'h201, 32'h0, SW, 1'b1, 1'b1);
		hit(1'b0, 32'h202, 32'h0, SW, 1'b0, 1'b0);
		wr(MSK, 32'h000F);
		wr(CTL, 32'h0080);
		hit(1'b0, 32'h200, 32'h5555_123F, SW, 1'b1, 1'b1);
		hit(1'b0, 32'h200, 32'h5555_023F, SW, 1'b0, 1'b0);
		hit(1'b0, 32'h204, 32'hAAAA_1234, SW, 1'b0, 1'b0);
		hit(1'b1, 32'h200, 32'hAAAA_1234, SW, 1'b0, 1'b0);
		{break_data_value_b_i, size_sel_b_i} <= {32'h3434, SB};
		wr(MSK, 32'h0);
		hit(1'b0, 32'h200, 32'hFFFF_3434, SB, 1'b1, 1'b1);
		hit(1'b0, 32'h201, 32'hFFFF_3434, SB, 1'b0, 1'b0);
		// Chained channels: B counts only after an earlier A match.
		{cond_ok_a_i, break_addr_b_i, size_sel_b_i} <= {1'b1, 32'h400, SL};
		wr(CTL, 32'h0008);
		hit(1'b0, 32'h400, 32'h0, SL, 1'b0, 1'b0);
		hit(1'b1, 32'h100, 32'h0, SL, 1'b0, 1'b0);
		hit(1'b0, 32'h400, 32'h0, SL, 1'b1, 1'b1);
		rd(CTL, 32'h4008, "control");
		break_addr_b_i <= 32'h100;
		hit(1'b1, 32'h100, 32'h0, SL, 1'b0, 1'b0);
		// No size programmed: the cycle's own size picks the address bits.
		{cond_ok_a_i, size_sel_b_i, break_addr_b_i} <=
			{1'b0, UBDMC_SZ_ANY, 32'h0000_0200};
		wr(CTL, 32'h0);
		hit(1'b0, 32'h201, 32'h0, SW, 1'b1, 1'b1);
		hit(1'b0, 32'h201, 32'h0, SB, 1'b0, 1'b0);
		end_sim();
	end
endmodule : testbench

/* File: tb/ubdmc_core_model.sv */
/* Behavioural core bus: one cycle per call of cycle().
   Assumes callers start right after a rising clock edge. */
`timescale 1ns/1ps
module ubdmc_core_model (
	input  wire logic        clk_i,   // Clock.
	output logic             valid_o, // Cycle present.
	output logic             fetch_o, // Fetch cycle.
	output logic [31:0]      addr_o,  // Address.
	output logic [31:0]      data_o,  // Data.
	output logic [1:0]       size_o   // Access size.
);
	// After a cycle the address and data lines show inverted values so a stale value never matches.
	initial begin
		{valid_o, fetch_o, addr_o, data_o, size_o} = '0;
	end

	task cycle(input logic f, input logic [31:0] a, d,
		input logic [1:0] s);
		{valid_o, fetch_o, addr_o, data_o, size_o} <= {1'b1, f, a, d, s};
		@(posedge clk_i);
		{valid_o, addr_o, data_o} <= {1'b0, ~a, ~d};
	endtask : cycle
endmodule : ubdmc_core_model

/* File: tb/ubdmc_properties.sv */
/* Checker of bus, trap and interrupt timing at the block's ports.
   Assumes classic Wishbone masters and a synchronous reset. */
`timescale 1ns/1ps
module ubdmc_properties
	import ubdmc_pkg::*;
(
	input wire logic        clk_i,         // Clock.
	input wire logic        rst_i,         // Reset.
	input wire logic        wb_cyc_i,      // Cycle.
	input wire logic        wb_stb_i,      // Strobe.
	input wire logic        wb_we_i,       // Write.
	input wire logic [7:0]  wb_adr_i,      // Address.
	input wire logic [31:0] wb_dat_o,      // Read data.
	input wire logic        wb_ack_o,      // Ack.
	input wire logic        bus_valid_i,   // Core cycle.
	input wire logic        bus_fetch_i,   // Fetch.
	input wire logic        cond_ok_a_i,   // A terms.
	input wire logic        cond_ok_b_i,   // B terms.
	input wire logic        break_trap_o,  // Trap.
	input wire logic        break_after_o, // Post.
	input wire logic        irq_o          // Interrupt.
);
	// ****************************************
	// Properties, all held off during reset.
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("data leak");
	// Reserved control bits and the upper half must read as zero.
	property p_resv_zero; wb_ack_o && !wb_we_i && wb_adr_i ==
		UBDMC_OFF_CONTROL |-> (wb_dat_o & 32'hFFFF_3B37) == 32'h0;
	endproperty
	a_resv_zero: assert property (p_resv_zero)
		else $error("reserved bit set");
	property p_no_cond; bus_valid_i && !cond_ok_a_i && !cond_ok_b_i
		|=> !break_trap_o;
	endproperty
	a_no_cond: assert property (p_no_cond) else $error("stray trap");
	property p_trap_cause; break_trap_o |-> $past(bus_valid_i);
	endproperty
	a_trap_cause: assert property (p_trap_cause)
		else $error("trap without cycle");
	property p_after_data; break_trap_o && !$past(bus_fetch_i)
		|-> break_after_o;
	endproperty
	a_after_data: assert property (p_after_data) else $error("data pre");
	// Sticky status: irq may only fall after a register write.
	property p_irq_hold; irq_o && !wb_ack_o && !$past(wb_ack_o) |=> irq_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq fell");
endmodule : ubdmc_properties

bind ubdmc_top ubdmc_properties i_props (
	.clk_i         (clk_i),
	.rst_i         (rst_i),
	.wb_cyc_i      (wb_cyc_i),
	.wb_stb_i      (wb_stb_i),
	.wb_we_i       (wb_we_i),
	.wb_adr_i      (wb_adr_i),
	.wb_dat_o      (wb_dat_o),
	.wb_ack_o      (wb_ack_o),
	.bus_valid_i   (bus_valid_i),
	.bus_fetch_i   (bus_fetch_i),
	.cond_ok_a_i   (cond_ok_a_i),
	.cond_ok_b_i   (cond_ok_b_i),
	.break_trap_o  (break_trap_o),
	.break_after_o (break_after_o),
	.irq_o         (irq_o)
);
